// ==== hdl/frtu_regs.svh ====
`ifndef FRTU_REGS_SVH
`define FRTU_REGS_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define FRTU_PLAIN_READ_CMD          8'h03
`define FRTU_PLAIN_READ_4BYTE_CMD    8'h13
`define FRTU_FAST_READ_CMD           8'h0b
`define FRTU_OCTAL_DDR_READ_CMD      8'hee
`define FRTU_GENERIC_REG_READ_CMD    8'h65
`define FRTU_STATUS1_READ_CMD        8'h05
`define FRTU_STATUS2_READ_CMD        8'h07
`define FRTU_DYNAMIC_PROT_READ_CMD   8'he0
`define FRTU_PERSISTENT_PROT_READ_CMD 8'he2
`define FRTU_PROT_LOCK_READ_CMD      8'ha7

// ----------------------------------------------------------------------------
// Generic register read map
// ----------------------------------------------------------------------------
`define FRTU_VOLATILE_BIT            23
`define FRTU_ADDR_STATUS1            24'h800000
`define FRTU_ADDR_STATUS2            24'h800001
`define FRTU_ADDR_ARRAY_LAT_V        24'h800003
`define FRTU_ADDR_VOL_LAT_V          24'h800004
`define FRTU_ADDR_ARRAY_LAT_N        24'h000003
`define FRTU_ADDR_VOL_LAT_N          24'h000004
`define FRTU_ADDR_PROT_MODE          24'h000030
`define FRTU_ADDR_PASSWORD           24'h000020
`define FRTU_PASSWORD_HI             24'h000027
`define FRTU_UNDEFINED_DATA          8'h00
`define FRTU_INVALID_PASSWORD        8'hff

// ----------------------------------------------------------------------------
// Fields and timing
// ----------------------------------------------------------------------------
`define FRTU_PROT_MODE_PASSWORD      3'b011
`define FRTU_DS_PREDRIVE_HALF        3'h5
`define FRTU_WRAP_BASE_BYTES         7'h08

`endif

// ==== hdl/frtu_pkg.sv ====
package frtu_pkg;

  // Link transaction phases
  typedef enum logic [2:0] {
    FRTU_CMD,
    FRTU_ADDR,
    FRTU_LAT,
    FRTU_DATA,
    FRTU_HALT
  } frtu_state_e;

  // Kind of read decoded from the command
  typedef enum logic [3:0] {
    FRTU_K_NONE,
    FRTU_K_PLAIN,
    FRTU_K_ARRAY,
    FRTU_K_GENERIC,
    FRTU_K_STAT1,
    FRTU_K_STAT2,
    FRTU_K_DYN,
    FRTU_K_PERS,
    FRTU_K_LOCK
  } frtu_kind_e;

endpackage

// ==== hdl/frtu_array.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Byte memory standing in for the flash array, registered read
// ----------------------------------------------------------------------------
module frtu_array #(
  parameter int AW = 16
) (
  // Clock
  input  wire logic          i_clock,
  // Load port
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [7:0]    i_wr_data,
  // Read port
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [7:0]    o_rd_data
);

  logic [7:0] mem [0:(1<<AW)-1];

  // Write and registered read
  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end

endmodule

`default_nettype wire

// ==== hdl/frtu_read_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "frtu_regs.svh"

module frtu_read_unit #(
  parameter int AW = 16
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_resetn,
  // Link pins
  input  wire logic          i_sck,
  input  wire logic          i_cs_n,
  input  wire logic [7:0]    i_dq,
  output logic      [7:0]    o_dq,
  output logic               o_dq_oe_n,
  output logic               o_ds,
  output logic               o_ds_oe_n,
  // Interface configuration
  input  wire logic          i_octal_enable,
  input  wire logic          i_ddr_enable,
  input  wire logic [7:0]    i_array_latency_config,
  input  wire logic [7:0]    i_volatile_latency_config,
  input  wire logic          i_wrap_enable,
  input  wire logic [1:0]    i_wrap_len,
  // Register contents
  input  wire logic [7:0]    i_first_status_volatile,
  input  wire logic [7:0]    i_status2_volatile,
  input  wire logic [7:0]    i_protection_mode_select,
  input  wire logic [63:0]   i_password,
  input  wire logic [7:0]    i_dynamic_prot_access,
  input  wire logic [7:0]    i_persistent_prot_access,
  input  wire logic [7:0]    i_prot_lock,
  output logic      [31:0]   o_prot_addr,
  // Array load port
  input  wire logic          i_load_en,
  input  wire logic [AW-1:0] i_load_addr,
  input  wire logic [7:0]    i_load_data
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Command byte to read kind
  function automatic frtu_pkg::frtu_kind_e cmd_kind(input logic [7:0] c);
    frtu_pkg::frtu_kind_e k;
    k = frtu_pkg::FRTU_K_NONE;
    case (c)
      `FRTU_PLAIN_READ_CMD:           k = frtu_pkg::FRTU_K_PLAIN;
      `FRTU_PLAIN_READ_4BYTE_CMD:     k = frtu_pkg::FRTU_K_PLAIN;
      `FRTU_FAST_READ_CMD:            k = frtu_pkg::FRTU_K_ARRAY;
      `FRTU_OCTAL_DDR_READ_CMD:       k = frtu_pkg::FRTU_K_ARRAY;
      `FRTU_GENERIC_REG_READ_CMD:     k = frtu_pkg::FRTU_K_GENERIC;
      `FRTU_STATUS1_READ_CMD:         k = frtu_pkg::FRTU_K_STAT1;
      `FRTU_STATUS2_READ_CMD:         k = frtu_pkg::FRTU_K_STAT2;
      `FRTU_DYNAMIC_PROT_READ_CMD:    k = frtu_pkg::FRTU_K_DYN;
      `FRTU_PERSISTENT_PROT_READ_CMD: k = frtu_pkg::FRTU_K_PERS;
      `FRTU_PROT_LOCK_READ_CMD:       k = frtu_pkg::FRTU_K_LOCK;
      default:                        k = frtu_pkg::FRTU_K_NONE;
    endcase
    return k;
  endfunction

  // Address bytes expected after the command
  function automatic logic [2:0] addr_bytes(input frtu_pkg::frtu_kind_e k,
                                            input logic c4, input logic oct);
    logic [2:0] n;
    n = 3'h0;
    if (oct)
    begin
      n = 3'h4; // Status and lock reads take four zero bytes
    end
    else if (k == frtu_pkg::FRTU_K_STAT1 || k == frtu_pkg::FRTU_K_STAT2 ||
             k == frtu_pkg::FRTU_K_LOCK)
    begin
      n = 3'h0;
    end
    else
    begin
      n = c4 ? 3'h4 : 3'h3;
    end
    return n;
  endfunction

  // Latency cycles chosen by kind and address
  function automatic logic [3:0] lat_sel(input frtu_pkg::frtu_kind_e k, input logic oct,
                                         input logic vol, input logic [3:0] arr,
                                         input logic [1:0] vl);
    logic [3:0] l;
    l = 4'h0;
    unique case (k)
      frtu_pkg::FRTU_K_PLAIN:   l = oct ? arr : 4'h0;
      frtu_pkg::FRTU_K_ARRAY:   l = arr;
      frtu_pkg::FRTU_K_GENERIC: l = vol ? {2'b00, vl} : arr;
      frtu_pkg::FRTU_K_PERS:    l = arr;
      frtu_pkg::FRTU_K_STAT1,
      frtu_pkg::FRTU_K_STAT2,
      frtu_pkg::FRTU_K_DYN,
      frtu_pkg::FRTU_K_LOCK:    l = {2'b00, vl};
      frtu_pkg::FRTU_K_NONE:    l = 4'h0;
    endcase
    return l;
  endfunction

  // Next array address, linear or wrapped inside an aligned group
  function automatic logic [AW-1:0] next_array(input logic [AW-1:0] a,
                                               input logic wen, input logic [1:0] wl);
    logic [AW-1:0] mask;
    logic [AW-1:0] inc;
    mask = AW'((`FRTU_WRAP_BASE_BYTES << wl) - 7'h01);
    inc  = a + AW'(1); // Top address rolls over to zero
    return wen ? ((a & ~mask) | (inc & mask)) : inc;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic                 sck_s1, sck_s2, sck_d;
  logic                 cs_s1, cs_s2;
  logic [7:0]           dq_s1, dq_s2;
  frtu_pkg::frtu_state_e state, next_state;
  frtu_pkg::frtu_kind_e  kind, next_kind;
  logic                 cmd4, next_cmd4;
  logic [31:0]          shift, next_shift;
  logic [31:0]          addr, next_addr;
  logic [5:0]           cnt, next_cnt;
  logic [2:0]           nbytes, next_nbytes;
  logic [3:0]           lat_cnt, next_lat_cnt;
  logic [2:0]           half, next_half;
  logic [2:0]           bit_cnt, next_bit_cnt;
  logic [7:0]           hold, next_hold;
  logic [7:0]           dq_out, next_dq_out;
  logic                 dq_oe, next_dq_oe;
  logic                 ds, next_ds;
  logic                 ds_oe, next_ds_oe;
  logic [7:0]           mem_rd_data;
  logic [7:0]           src;

  // Edge detection on the synchronised link clock
  logic rise, fall, oct, ddr, in_beat, out_edge;
  assign rise     = sck_s2 & ~sck_d;
  assign fall     = ~sck_s2 & sck_d;
  assign oct      = i_octal_enable;
  assign ddr      = i_octal_enable & i_ddr_enable;
  assign in_beat  = rise | (ddr & fall);
  assign out_edge = fall | (ddr & rise);

  frtu_array #(
    .AW (AW)
  ) u_array (
    .i_clock   (i_clock),
    .i_wr_en   (i_load_en),
    .i_wr_addr (i_load_addr),
    .i_wr_data (i_load_data),
    .i_rd_addr (addr[AW-1:0]),
    .o_rd_data (mem_rd_data)
  );

  // --------------------------------------------------------------------------
  // Byte source for the data phase
  // --------------------------------------------------------------------------

  // Live register values, so status reflects any operation in flight
  always_comb
  begin
    src = `FRTU_UNDEFINED_DATA;
    unique case (kind)
      frtu_pkg::FRTU_K_PLAIN,
      frtu_pkg::FRTU_K_ARRAY:   src = mem_rd_data;
      frtu_pkg::FRTU_K_STAT1:   src = i_first_status_volatile;
      frtu_pkg::FRTU_K_STAT2:   src = i_status2_volatile;
      frtu_pkg::FRTU_K_DYN:     src = i_dynamic_prot_access;
      frtu_pkg::FRTU_K_PERS:    src = i_persistent_prot_access;
      frtu_pkg::FRTU_K_LOCK:    src = i_prot_lock;
      frtu_pkg::FRTU_K_NONE:    src = `FRTU_UNDEFINED_DATA;
      frtu_pkg::FRTU_K_GENERIC:
      begin
        // No busy gating, so it works during embedded operations
        if (addr[23:0] == `FRTU_ADDR_STATUS1)
          src = i_first_status_volatile;
        else if (addr[23:0] == `FRTU_ADDR_STATUS2)
          src = i_status2_volatile;
        else if (addr[23:0] == `FRTU_ADDR_ARRAY_LAT_V || addr[23:0] == `FRTU_ADDR_ARRAY_LAT_N)
          src = i_array_latency_config;
        else if (addr[23:0] == `FRTU_ADDR_VOL_LAT_V || addr[23:0] == `FRTU_ADDR_VOL_LAT_N)
          src = i_volatile_latency_config;
        else if (addr[23:0] == `FRTU_ADDR_PROT_MODE)
          src = i_protection_mode_select;
        else if (addr[23:0] >= `FRTU_ADDR_PASSWORD && addr[23:0] <= `FRTU_PASSWORD_HI)
          src = (i_protection_mode_select[2:0] == `FRTU_PROT_MODE_PASSWORD) ?
                `FRTU_INVALID_PASSWORD : i_password[{addr[2:0], 3'b000} +: 8];
        else
          src = `FRTU_UNDEFINED_DATA;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Transaction sequencer
  // --------------------------------------------------------------------------

  // Next values of all transaction state
  always_comb
  begin
    logic [31:0] v_addr;
    logic [7:0]  v_cmd;
    logic        v_start;
    frtu_pkg::frtu_kind_e v_kind;
    logic [3:0]  v_lat;
    v_addr       = 32'h0;
    v_cmd        = 8'h00;
    v_start      = 1'b0;
    v_kind       = kind;
    v_lat        = 4'h0;
    next_state   = state;
    next_kind    = kind;
    next_cmd4    = cmd4;
    next_shift   = shift;
    next_addr    = addr;
    next_cnt     = cnt;
    next_nbytes  = nbytes;
    next_lat_cnt = lat_cnt;
    next_half    = half;
    next_bit_cnt = bit_cnt;
    next_hold    = hold;
    next_dq_out  = dq_out;
    next_dq_oe   = dq_oe;
    next_ds      = ds;
    next_ds_oe   = ds_oe;
    if (cs_s2)
    begin
      // Deselect aborts and releases the pins
      next_state  = frtu_pkg::FRTU_CMD;
      next_shift  = 32'h0;
      next_cnt    = 6'h0;
      next_dq_oe  = 1'b0;
      next_ds_oe  = 1'b0;
      next_ds     = 1'b0;
      next_half   = 3'h0;
    end
    else
    begin
      unique case (state)
        frtu_pkg::FRTU_CMD:
        begin
          if (in_beat)
          begin
            next_cnt = cnt + 6'h1;
            if (!oct)
            begin
              next_shift = {shift[30:0], dq_s2[0]}; // One bit per rising edge
              v_cmd      = {shift[6:0], dq_s2[0]};
              v_start    = (cnt == 6'h7);
            end
            else
            begin
              if (cnt == 6'h0)
                next_shift = {24'h0, dq_s2};        // First byte carries the code
              v_cmd   = shift[7:0];
              v_start = (cnt == 6'h1);
            end
            if (v_start)
            begin
              v_kind      = cmd_kind(v_cmd);
              next_kind   = v_kind;
              next_cmd4   = (v_cmd == `FRTU_PLAIN_READ_4BYTE_CMD) ||
                            (v_cmd == `FRTU_DYNAMIC_PROT_READ_CMD) ||
                            (v_cmd == `FRTU_PERSISTENT_PROT_READ_CMD);
              next_nbytes = addr_bytes(v_kind, next_cmd4, oct);
              next_shift  = 32'h0;
              next_cnt    = 6'h0;
              if (v_kind == frtu_pkg::FRTU_K_NONE)
                next_state = frtu_pkg::FRTU_HALT;
              else if (next_nbytes != 3'h0)
                next_state = frtu_pkg::FRTU_ADDR;
              else
                v_start = 1'b1;
            end
            v_start = v_start && (v_kind != frtu_pkg::FRTU_K_NONE) && (next_nbytes == 3'h0);
          end
        end
        frtu_pkg::FRTU_ADDR:
        begin
          if (in_beat)
          begin
            next_cnt = cnt + 6'h1;
            if (!oct)
            begin
              next_shift = {shift[30:0], dq_s2[0]};
              v_start    = (cnt == {nbytes - 3'h1, 3'b111}); // Last bit of the last address byte
            end
            else
            begin
              next_shift = {shift[23:0], dq_s2};
              v_start    = (cnt == {3'b000, nbytes - 3'h1});
            end
            v_addr = next_shift; // Only the last address byte starts the read
          end
        end
        frtu_pkg::FRTU_LAT:
        begin
          if (rise)
          begin
            next_lat_cnt = lat_cnt - 4'h1;
            if (lat_cnt == 4'h1)
              next_state = frtu_pkg::FRTU_DATA;
          end
        end
        frtu_pkg::FRTU_DATA:
        begin
          if (out_edge)
          begin
            next_dq_oe = 1'b1;
            if (!oct)
            begin
              // Serial out on the second data line, no strobe
              next_hold    = (bit_cnt == 3'h7) ? src : hold; // Status refreshed per byte
              next_dq_out  = {6'h0, ((bit_cnt == 3'h7) ? src[7] : hold[bit_cnt]), 1'b0};
              next_bit_cnt = bit_cnt - 3'h1;
            end
            else
            begin
              next_dq_out = src;
              next_ds_oe  = 1'b1;
              if (ddr)
                next_ds = ~ds;     // Edge-aligned strobe
            end
            if ((oct || bit_cnt == 3'h0) &&
                (kind == frtu_pkg::FRTU_K_PLAIN || kind == frtu_pkg::FRTU_K_ARRAY))
              next_addr = {{(32-AW){1'b0}}, next_array(addr[AW-1:0], i_wrap_enable, i_wrap_len)};
            // Register reads keep their location
          end
          else if (rise && oct && !ddr && dq_oe)
          begin
            next_ds = ~ds;         // Centre-aligned strobe
          end
        end
        frtu_pkg::FRTU_HALT:
        begin
          next_state = frtu_pkg::FRTU_HALT;
        end
      endcase

      // Enter latency or data once command and address are complete
      if (v_start)
      begin
        next_addr    = v_addr;
        v_lat        = lat_sel(next_kind, oct, v_addr[`FRTU_VOLATILE_BIT],
                               i_array_latency_config[3:0], i_volatile_latency_config[7:6]);
        next_lat_cnt = v_lat;
        next_half    = 3'h0;
        next_bit_cnt = 3'h7;
        next_state   = (v_lat == 4'h0) ? frtu_pkg::FRTU_DATA : frtu_pkg::FRTU_LAT;
      end

      // Strobe pre-drive low five half-cycles after the address
      if (oct && !v_start && (state == frtu_pkg::FRTU_LAT || state == frtu_pkg::FRTU_DATA) &&
          (rise || fall) && half != `FRTU_DS_PREDRIVE_HALF)
      begin
        next_half = half + 3'h1;
        if (half == `FRTU_DS_PREDRIVE_HALF - 3'h1)
        begin
          next_ds_oe = 1'b1;
        end
      end
    end
  end

  // Synchronisers and state registers
  always_ff @(posedge i_clock)
  begin
    if (!i_resetn)
    begin
      sck_s1  <= 1'b0;
      sck_s2  <= 1'b0;
      sck_d   <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
      state   <= frtu_pkg::FRTU_CMD;
      kind    <= frtu_pkg::FRTU_K_NONE;
      cmd4    <= 1'b0;
      shift   <= 32'h0;
      addr    <= 32'h0;
      cnt     <= 6'h0;
      nbytes  <= 3'h0;
      lat_cnt <= 4'h0;
      half    <= 3'h0;
      bit_cnt <= 3'h7;
      hold    <= 8'h00;
      dq_out  <= 8'h00;
      dq_oe   <= 1'b0;
      ds      <= 1'b0;
      ds_oe   <= 1'b0;
    end
    else
    begin
      sck_s1  <= i_sck;
      sck_s2  <= sck_s1;
      sck_d   <= sck_s2;
      cs_s1   <= i_cs_n;
      cs_s2   <= cs_s1;
      dq_s1   <= i_dq;
      dq_s2   <= dq_s1;
      state   <= next_state;
      kind    <= next_kind;
      cmd4    <= next_cmd4;
      shift   <= next_shift;
      addr    <= next_addr;
      cnt     <= next_cnt;
      nbytes  <= next_nbytes;
      lat_cnt <= next_lat_cnt;
      half    <= next_half;
      bit_cnt <= next_bit_cnt;
      hold    <= next_hold;
      dq_out  <= next_dq_out;
      dq_oe   <= next_dq_oe;
      ds      <= next_ds;
      ds_oe   <= next_ds_oe;
    end
  end

  // Pin drivers, enables active low
  assign o_dq        = dq_out;
  assign o_dq_oe_n   = ~dq_oe;
  assign o_ds        = ds;
  assign o_ds_oe_n   = ~ds_oe;
  assign o_prot_addr = addr;

endmodule

`default_nettype wire

// ==== verification/frtu_read_unit_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

// --------
// Port checks on the read unit
// --------
module frtu_read_unit_chk (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_resetn,
  // Link and mode
  input wire logic        i_cs_n,
  input wire logic        i_octal_enable,
  input wire logic [7:0]  o_dq,
  input wire logic        o_dq_oe_n,
  input wire logic        o_ds,
  input wire logic        o_ds_oe_n,
  input wire logic [31:0] o_prot_addr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  // Deselected and single-bit stretches, long enough for the synchronisers
  sequence s_idle; i_cs_n [*5]; endsequence
  sequence s_single; !i_octal_enable [*4]; endsequence

  out_reset_a: assert property ($rose(i_resetn) |-> o_dq_oe_n && o_ds_oe_n && o_prot_addr == 32'h0)
    else $error("outputs not cleared by reset");
  idle_release_a: assert property (s_idle |-> o_dq_oe_n && o_ds_oe_n)
    else $error("outputs driven while deselected");
  abort_release_a: assert property ($rose(i_cs_n) |-> ##[1:5] (o_dq_oe_n && o_ds_oe_n))
    else $error("outputs not released after deselect");
  single_no_ds_a: assert property (s_single |-> o_ds_oe_n)
    else $error("strobe driven in single-bit mode");
  single_lanes_a: assert property (s_single ##0 !o_dq_oe_n |-> (o_dq & 8'hfd) == 8'h00)
    else $error("single-bit data on a wrong lane");
  ds_predrive_a: assert property ($fell(o_ds_oe_n) |-> !o_ds)
    else $error("strobe not driven low first");
  drive_selected_a: assert property ($fell(o_dq_oe_n) |-> !i_cs_n)
    else $error("data driven without selection");
  ds_with_data_a: assert property (i_octal_enable && $fell(o_dq_oe_n) |-> !o_ds_oe_n)
    else $error("octal data without strobe");
endmodule

bind frtu_read_unit frtu_read_unit_chk i_frtu_read_unit_chk (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_cs_n(i_cs_n), .i_octal_enable(i_octal_enable), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_ds(o_ds),
  .o_ds_oe_n(o_ds_oe_n), .o_prot_addr(o_prot_addr));

`default_nettype wire

// ==== verification/frtu_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// --------
// Host controller: frames, clocks and captures one read
// --------
module frtu_host_model (
  // Link pins
  output logic            o_sck,
  output logic            o_cs_n,
  output logic      [7:0] o_dq,
  input  wire logic [7:0] i_dq
);
  // Idle link, clock stands low outside frames
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_dq = 8'h00;
  end

  // Command, address, latency, then nd bytes sampled at the next output edge
  task automatic xfer(input logic oct, input logic ddr, input logic [7:0] cmd, input int na,
                      input logic [31:0] adr, input int lat, input int nd, output logic [63:0] rd);
    logic [7:0] b[$];
    int         step, nb, hl, hlat, hd, hend;
    b = {cmd};
    if (oct)
      b.push_back(8'h00);                   // Second command byte
    for (int k = na - 1; k >= 0; k--)
      b.push_back(adr[8*k+:8]);             // Zero bytes for status and lock
    step = ddr ? 1 : 2;                     // Both edges in DDR
    nb = oct ? b.size() : 8 * b.size();
    hl = step * (nb - 1) + 1;
    hlat = hl + 2 * lat - ((hl % 2 == 0 && lat > 0) ? 1 : 0);
    hd = hlat + 2 - hlat % 2;
    hend = hd + step * (oct ? nd : 8 * nd);
    rd = 64'h0;
    #7 o_cs_n = 1'b0;
    for (int h = 0; h <= hend; h++)
    begin
      o_sck = h[0];
      if (h > hd && (h - hd) % step == 0)
        rd = oct ? {rd[55:0], i_dq} : {rd[62:0], i_dq[1]};
      #40;                                  // 160 ns period
      if (h % step == 0 && h / step < nb)
        o_dq = oct ? b[h/step] : {7'h00, b[h/16][7-(h/2)%8]};
      else
        o_dq = ~o_dq;                       // Undriven beats never repeat the last value
      #40;
    end
    o_cs_n = 1'b1;                          // One frame per read, covering all nd bytes
    #80 o_sck = 1'b0;
    #160;
  endtask
endmodule

`default_nettype wire

// ==== verification/tb_frtu_read_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "frtu_regs.svh"

module tb_frtu_read_unit;
  logic        i_clock, i_resetn, i_sck, i_cs_n, i_octal_enable, i_ddr_enable, i_wrap_enable, i_load_en;
  logic        o_dq_oe_n, o_ds, o_ds_oe_n;
  logic [1:0]  i_wrap_len;
  logic [7:0]  i_dq, o_dq, i_load_data, i_array_latency_config, i_volatile_latency_config, i_prot_lock;
  logic [7:0]  i_first_status_volatile, i_status2_volatile, i_protection_mode_select;
  logic [7:0]  i_dynamic_prot_access, i_persistent_prot_access;
  logic [15:0] i_load_addr;
  logic [31:0] o_prot_addr;
  logic [63:0] i_password;
  logic [7:0]  host_dq;
  int          err_total, comparisons, tests;

  // Released data lines show the inverse of the last value, so a late enable is caught
  assign host_dq = o_dq_oe_n ? ~o_dq : o_dq;

  frtu_read_unit i_frtu_read_unit (
    .i_clock, .i_resetn, .i_sck, .i_cs_n, .i_dq, .o_dq, .o_dq_oe_n, .o_ds, .o_ds_oe_n, .i_octal_enable,
    .i_ddr_enable, .i_array_latency_config, .i_volatile_latency_config, .i_wrap_enable, .i_wrap_len,
    .i_first_status_volatile, .i_status2_volatile, .i_protection_mode_select, .i_password,
    .i_dynamic_prot_access, .i_persistent_prot_access, .i_prot_lock, .o_prot_addr, .i_load_en,
    .i_load_addr, .i_load_data);
  frtu_host_model i_frtu_host_model (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_dq(i_dq), .i_dq(host_dq));

  // 50 MHz clock
  initial i_clock = 1'b0;
  always #10 i_clock = ~i_clock;

  // Array contents derive from the address
  function automatic logic [7:0] f(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  // Compare read data
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  // One read frame in the given mode
  task automatic run(input logic o, input logic d, input logic [7:0] cmd, input int na, input logic [31:0] adr,
                     input int lat, input int nd, input logic [63:0] exp);
    logic [63:0] rd;
    @(posedge i_clock);
    i_octal_enable <= o;
    i_ddr_enable <= d;
    i_frtu_host_model.xfer(o, d, cmd, na, adr, lat, nd, rd);
    check(rd, exp);
    tests++;
    $display("Test %0d done", tests);
  endtask

  // Counts and verdict
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {i_resetn, i_load_en, i_wrap_enable, i_octal_enable, i_ddr_enable, i_wrap_len} = 7'h00;
    {i_load_addr, i_load_data, i_protection_mode_select} = 32'h0;
    {i_array_latency_config, i_volatile_latency_config} = 16'h04c0;
    {i_first_status_volatile, i_status2_volatile, i_dynamic_prot_access} = 24'h813c96;
    {i_persistent_prot_access, i_prot_lock} = 16'h69fe;
    i_password = 64'h0123456789abcdef;
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    for (int a = -2; a < 8; a++)
    begin
      @(posedge i_clock);
      i_load_en <= 1'b1;
      i_load_addr <= 16'(a);
      i_load_data <= f(16'(a));
    end
    @(posedge i_clock);
    i_load_en <= 1'b0;
    run(0, 0, `FRTU_PLAIN_READ_CMD, 3, 32'h1, 0, 2, {f(1), f(2)});
    run(0, 0, `FRTU_FAST_READ_CMD, 3, 32'hfffe, 4, 4, {f(16'hfffe), f(16'hffff), f(0), f(1)});
    run(0, 0, `FRTU_PLAIN_READ_4BYTE_CMD, 4, 32'h5, 0, 2, {f(5), f(6)});
    run(0, 0, `FRTU_GENERIC_REG_READ_CMD, 3, `FRTU_ADDR_STATUS1, 3, 2, 16'h8181);
    run(0, 0, `FRTU_GENERIC_REG_READ_CMD, 3, `FRTU_ADDR_ARRAY_LAT_N, 4, 1, 8'h04);
    run(0, 0, `FRTU_GENERIC_REG_READ_CMD, 3, 32'h10, 4, 1, `FRTU_UNDEFINED_DATA);
    for (int m = 0; m < 4; m += 3)
    begin
      @(posedge i_clock) i_protection_mode_select <= 8'(m);
      run(0, 0, `FRTU_GENERIC_REG_READ_CMD, 3, 32'h21, 4, 1, m == 3 ? `FRTU_INVALID_PASSWORD : 8'hcd);
    end
    run(0, 0, `FRTU_STATUS1_READ_CMD, 0, 32'h0, 3, 2, 16'h8181);
    run(0, 0, `FRTU_STATUS2_READ_CMD, 0, 32'h0, 3, 1, 8'h3c);
    run(0, 0, `FRTU_DYNAMIC_PROT_READ_CMD, 4, 32'h9, 3, 2, 16'h9696);
    check(64'(o_prot_addr), 64'h9);
    run(0, 0, `FRTU_PERSISTENT_PROT_READ_CMD, 4, 32'h9, 4, 2, 16'h6969);
    run(0, 0, `FRTU_PROT_LOCK_READ_CMD, 0, 32'h0, 3, 2, 16'hfefe);
    run(1, 0, `FRTU_PLAIN_READ_CMD, 4, 32'h2, 4, 3, {f(2), f(3), f(4)});
    @(posedge i_clock) i_wrap_enable <= 1'b1;
    run(1, 1, `FRTU_OCTAL_DDR_READ_CMD, 4, 32'h6, 4, 4, {f(6), f(7), f(0), f(1)});
    @(posedge i_clock) i_wrap_enable <= 1'b0;
    run(1, 1, `FRTU_PROT_LOCK_READ_CMD, 4, 32'h0, 3, 2, 16'hfefe);
    final_report();
  end
endmodule

`default_nettype wire
